// ===== usb_state_pkg.sv
// Package: register map, field positions, reset values and carrier types of the USB state and mask block
package usb_state_pkg;

   // ****************************************************
   // Register offsets (byte addresses)
   // ****************************************************
   localparam logic [7:0] frame_info_off = 8'h00;
   localparam logic [7:0] device_state_off = 8'h04;
   localparam logic [7:0] function_address_off = 8'h08;
   localparam logic [7:0] irq_enable_set_off = 8'h10;
   localparam logic [7:0] irq_enable_clear_off = 8'h14;
   localparam logic [7:0] irq_mask_state_off = 8'h18;
   localparam logic [7:0] irq_status_off = 8'h1C;
   localparam logic [7:0] irq_clear_off = 8'h20;

   // ****************************************************
   // Field positions
   // ****************************************************
   localparam int frame_count_w = 11;
   localparam int frame_bad_pos = 16;
   localparam int frame_good_pos = 17;
   localparam int address_state_pos = 0;
   localparam int configured_pos = 1;
   localparam int function_addr_w = 7;
   localparam int function_enable_pos = 8;
   localparam int suspend_pos = 8;
   localparam int resume_pos = 9;
   localparam int frame_start_pos = 11;
   localparam int bus_reset_done_pos = 12;
   localparam int wakeup_pos = 13;
   localparam int irq_w = 14;

   // Byte-lane view of the frame flags for an 8-bit register port
   localparam int frame_good_byte_pos = 4;
   localparam int frame_bad_byte_pos = 3;

   // ****************************************************
   // Reset values and masks
   // ****************************************************
   localparam logic [13:0] irq_mask_reset = 14'h0200;
   localparam logic [13:0] irq_valid_bits = 14'h2B3F;
   localparam logic [13:0] irq_fixed_on = 14'h1000;
   localparam logic [13:0] irq_status_bits = 14'h3B3F;
   localparam logic [6:0] function_addr_reset = 7'h00;

   // ****************************************************
   // Carrier types
   // ****************************************************
   typedef struct packed {
      logic sof_pid;
      logic sof_eop;
      logic sof_error;
      logic [10:0] sof_frame;
   } sof_event_type;

   typedef struct packed {
      logic [5:0] endpoint;
      logic suspend;
      logic resume;
      logic bus_reset_done;
      logic wakeup;
   } bus_event_type;

   typedef struct packed {
      logic address_state_enable;
      logic configured_state;
      logic function_enable;
      logic [6:0] function_addr_value;
   } device_ctrl_type;

endpackage

// ===== usb_device_state_irq.sv
// Device state, frame capture and interrupt mask registers behind an Avalon-MM slave

module usb_device_state_irq (
   input wire logic clk,
   input wire logic reset,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic avs_response_err,
   input wire usb_state_pkg::sof_event_type sof_in,
   input wire usb_state_pkg::bus_event_type events_in,
   output logic [7:0] frame_high_byte,
   output logic [7:0] frame_low_byte,
   output usb_state_pkg::device_ctrl_type ctrl_out,
   output logic irq
);

   // ****************************************************
   // Bus slave: one wait state, answer in the second cycle
   // ****************************************************
   logic wait_q;
   logic [31:0] readdata_q;
   logic err_q;
   logic access;
   logic wr_hit;
   logic full_word;

   assign access = (avs_read || avs_write) && wait_q;
   // Writes land at the edge at which the master sees waitrequest low
   assign wr_hit = avs_write && !wait_q;
   assign full_word = avs_byteenable[0] && avs_byteenable[1];

   always_ff @(posedge clk) begin
      if (reset) begin
         wait_q <= 1'b1;
      end else begin
         wait_q <= !access;
      end
   end

   assign avs_waitrequest = wait_q;

   // ****************************************************
   // Frame capture
   // ****************************************************
   logic [10:0] frame_count_q;
   logic frame_bad_flag_q;
   logic frame_good_flag_q;

   always_ff @(posedge clk) begin
      if (reset) begin
         frame_count_q <= 11'h000;
      end else if (sof_in.sof_eop) begin
         frame_count_q <= sof_in.sof_frame;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         frame_bad_flag_q <= 1'b0;
         frame_good_flag_q <= 1'b0;
      end else if (sof_in.sof_eop) begin
         frame_bad_flag_q <= sof_in.sof_error;
         frame_good_flag_q <= !sof_in.sof_error;
      end else if (sof_in.sof_pid) begin
         frame_bad_flag_q <= 1'b0;
         frame_good_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         frame_high_byte <= 8'h00;
         frame_low_byte <= 8'h00;
      end else begin
         frame_high_byte <= {3'h0, frame_good_flag_q, 1'b0, frame_count_q[10:8]};
         frame_low_byte <= {frame_count_q[7:4], frame_bad_flag_q, frame_count_q[2:0]};
      end
   end

   // ****************************************************
   // Device state and function address
   // ****************************************************
   logic address_state_enable_q;
   logic configured_state_q;
   logic function_enable_q;
   logic [6:0] function_addr_value_q;

   always_ff @(posedge clk) begin
      if (reset) begin
         address_state_enable_q <= 1'b0;
         configured_state_q <= 1'b0;
      end else if (wr_hit && avs_byteenable[0] && avs_address == usb_state_pkg::device_state_off) begin
         if (avs_writedata[usb_state_pkg::address_state_pos]) begin
            address_state_enable_q <= 1'b1;
         end
         configured_state_q <= avs_writedata[usb_state_pkg::configured_pos];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         function_addr_value_q <= usb_state_pkg::function_addr_reset;
         function_enable_q <= 1'b0;
      end else if (wr_hit && avs_address == usb_state_pkg::function_address_off) begin
         if (avs_byteenable[0]) begin
            function_addr_value_q <= avs_writedata[6:0];
         end
         if (avs_byteenable[1]) begin
            function_enable_q <= avs_writedata[usb_state_pkg::function_enable_pos];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         ctrl_out <= '0;
      end else begin
         ctrl_out.address_state_enable <= address_state_enable_q;
         ctrl_out.configured_state <= configured_state_q;
         ctrl_out.function_enable <= function_enable_q;
         ctrl_out.function_addr_value <= function_addr_value_q;
      end
   end

   // ****************************************************
   // Interrupt mask, status and output
   // ****************************************************
   logic [13:0] mask_q;
   logic [13:0] status_q;
   logic [13:0] raise;
   logic [13:0] mask_view;
   logic [13:0] clear_bits;

   assign mask_view = mask_q | usb_state_pkg::irq_fixed_on;

   always_ff @(posedge clk) begin
      if (reset) begin
         mask_q <= usb_state_pkg::irq_mask_reset;
      end else if (events_in.bus_reset_done) begin
         mask_q <= usb_state_pkg::irq_mask_reset;
      end else if (wr_hit && full_word) begin
         if (avs_address == usb_state_pkg::irq_enable_set_off) begin
            mask_q <= mask_q | (avs_writedata[13:0] & usb_state_pkg::irq_valid_bits);
         end else if (avs_address == usb_state_pkg::irq_enable_clear_off) begin
            mask_q <= mask_q & ~(avs_writedata[13:0] & usb_state_pkg::irq_valid_bits);
         end
      end
   end

   always_comb begin
      raise = '0;
      raise[5:0] = events_in.endpoint;
      raise[usb_state_pkg::suspend_pos] = events_in.suspend;
      raise[usb_state_pkg::resume_pos] = events_in.resume;
      raise[usb_state_pkg::frame_start_pos] = sof_in.sof_pid;
      raise[usb_state_pkg::bus_reset_done_pos] = events_in.bus_reset_done;
      raise[usb_state_pkg::wakeup_pos] = events_in.wakeup;
   end

   always_comb begin
      clear_bits = '0;
      if (wr_hit && full_word && avs_address == usb_state_pkg::irq_clear_off) begin
         clear_bits = avs_writedata[13:0] & usb_state_pkg::irq_status_bits;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         status_q <= '0;
      end else begin
         status_q <= (status_q & ~clear_bits) | raise; // set wins over clear
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status_q & mask_view);
      end
   end

   // ****************************************************
   // Read data
   // ****************************************************
   always_ff @(posedge clk) begin
      if (reset) begin
         readdata_q <= 32'h0000_0000;
         err_q <= 1'b0;
      end else if (access) begin
         readdata_q <= 32'h0000_0000;
         err_q <= 1'b0;
         if (avs_read) begin
            unique case (avs_address)
               usb_state_pkg::frame_info_off: readdata_q <= {14'h0000, frame_good_flag_q, frame_bad_flag_q,
                                                             5'h00, frame_count_q};
               usb_state_pkg::device_state_off: readdata_q <= {30'h0, configured_state_q, address_state_enable_q};
               usb_state_pkg::function_address_off: readdata_q <= {23'h0, function_enable_q, 1'b0,
                                                                   function_addr_value_q};
               usb_state_pkg::irq_mask_state_off: readdata_q <= {18'h0, mask_view};
               usb_state_pkg::irq_status_off: readdata_q <= {18'h0, status_q};
               usb_state_pkg::irq_enable_set_off,
               usb_state_pkg::irq_enable_clear_off,
               usb_state_pkg::irq_clear_off: readdata_q <= 32'h0000_0000;
               default: err_q <= 1'b1;
            endcase
         end else if (!(avs_address inside {usb_state_pkg::frame_info_off, usb_state_pkg::device_state_off,
                     usb_state_pkg::function_address_off, usb_state_pkg::irq_enable_set_off,
                     usb_state_pkg::irq_enable_clear_off, usb_state_pkg::irq_mask_state_off,
                     usb_state_pkg::irq_status_off, usb_state_pkg::irq_clear_off})) begin
            err_q <= 1'b1;
         end
      end
   end

   assign avs_readdata = readdata_q;
   assign avs_response_err = err_q;

   // ****************************************************
   // Assertions
   // ****************************************************
   sequence sof_end_clean;
      sof_in.sof_eop && !sof_in.sof_error;
   endsequence

   a_frame_capture: assert property (@(posedge clk) disable iff (reset)
      sof_in.sof_eop |=> frame_count_q == $past(sof_in.sof_frame))
      else $error("frame number not captured at packet end");

   a_frame_bad: assert property (@(posedge clk) disable iff (reset)
      sof_in.sof_eop && sof_in.sof_error |=> frame_bad_flag_q && !frame_good_flag_q)
      else $error("bad frame flag not set");

   a_frame_good: assert property (@(posedge clk) disable iff (reset)
      sof_end_clean |=> frame_good_flag_q && !frame_bad_flag_q)
      else $error("good frame flag not set");

   a_frame_pid_clear: assert property (@(posedge clk) disable iff (reset)
      sof_in.sof_pid && !sof_in.sof_eop |=> !frame_good_flag_q && !frame_bad_flag_q)
      else $error("frame flags not cleared at pid");

   a_sof_status: assert property (@(posedge clk) disable iff (reset)
      sof_in.sof_pid |=> status_q[usb_state_pkg::frame_start_pos])
      else $error("frame start status not raised at pid");

   a_address_sticky: assert property (@(posedge clk) disable iff (reset)
      address_state_enable_q |=> address_state_enable_q)
      else $error("address state left without reset");

   a_mask_fixed: assert property (@(posedge clk) disable iff (reset)
      mask_view[usb_state_pkg::bus_reset_done_pos])
      else $error("bus reset done source masked");

   a_mask_set: assert property (@(posedge clk) disable iff (reset)
      wr_hit && full_word && avs_address == usb_state_pkg::irq_enable_set_off && !events_in.bus_reset_done
      |=> (mask_q & ($past(avs_writedata[13:0]) & usb_state_pkg::irq_valid_bits))
          == ($past(avs_writedata[13:0]) & usb_state_pkg::irq_valid_bits))
      else $error("enable write did not set mask");

   a_irq_level: assert property (@(posedge clk) disable iff (reset)
      |(status_q & mask_view) |=> irq)
      else $error("interrupt not raised");

   a_bus_answer: assert property (@(posedge clk) disable iff (reset)
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus answer late");

   a_answer_once: assert property (@(posedge clk) disable iff (reset)
      !avs_waitrequest |=> avs_waitrequest)
      else $error("answer held longer than one cycle");

   sequence address_enter;
      wr_hit && avs_byteenable[0] && avs_address == usb_state_pkg::device_state_off
      && avs_writedata[usb_state_pkg::address_state_pos];
   endsequence

   sequence state_write;
      wr_hit && avs_byteenable[0] && avs_address == usb_state_pkg::device_state_off;
   endsequence

   sequence faddr_low_write;
      wr_hit && avs_byteenable[0] && avs_address == usb_state_pkg::function_address_off;
   endsequence

   sequence faddr_high_write;
      wr_hit && avs_byteenable[1] && avs_address == usb_state_pkg::function_address_off;
   endsequence

   sequence mask_clear_write;
      wr_hit && full_word && avs_address == usb_state_pkg::irq_enable_clear_off && !events_in.bus_reset_done;
   endsequence

   sequence mask_read_taken;
      access && avs_read && avs_address == usb_state_pkg::irq_mask_state_off;
   endsequence

   a_address_set: assert property (@(posedge clk) disable iff (reset)
      address_enter |=> address_state_enable_q)
      else $error("address state not entered");

   a_config_write: assert property (@(posedge clk) disable iff (reset)
      state_write |=> configured_state_q == $past(avs_writedata[usb_state_pkg::configured_pos]))
      else $error("configured state not written");

   a_faddr_write: assert property (@(posedge clk) disable iff (reset)
      faddr_low_write |=> function_addr_value_q == $past(avs_writedata[6:0]))
      else $error("function address not written");

   a_fen_write: assert property (@(posedge clk) disable iff (reset)
      faddr_high_write |=> function_enable_q == $past(avs_writedata[usb_state_pkg::function_enable_pos]))
      else $error("function enable not written");

   a_mask_clear: assert property (@(posedge clk) disable iff (reset)
      mask_clear_write
      |=> (mask_q & $past(avs_writedata[13:0]) & usb_state_pkg::irq_valid_bits) == 14'h0000)
      else $error("disable write did not clear mask");

   a_mask_read: assert property (@(posedge clk) disable iff (reset)
      mask_read_taken |=> avs_readdata == {18'h0, $past(mask_view)})
      else $error("mask read returned wrong value");

   a_mask_bus_reset: assert property (@(posedge clk) disable iff (reset)
      events_in.bus_reset_done |=> mask_q == usb_state_pkg::irq_mask_reset)
      else $error("mask not restored at bus reset end");

   a_bus_reset_status: assert property (@(posedge clk) disable iff (reset)
      events_in.bus_reset_done |=> status_q[usb_state_pkg::bus_reset_done_pos])
      else $error("bus reset done status not raised");

   a_wakeup_status: assert property (@(posedge clk) disable iff (reset)
      events_in.wakeup |=> status_q[usb_state_pkg::wakeup_pos])
      else $error("wakeup status not raised");

   a_frame_hold: assert property (@(posedge clk) disable iff (reset)
      !sof_in.sof_eop |=> $stable(frame_count_q))
      else $error("frame number changed without packet end");

   a_byte_view: assert property (@(posedge clk) disable iff (reset)
      !reset |=> frame_high_byte[usb_state_pkg::frame_good_byte_pos] == $past(frame_good_flag_q)
                 && frame_low_byte[usb_state_pkg::frame_bad_byte_pos] == $past(frame_bad_flag_q))
      else $error("byte view flags misplaced");

   a_irq_quiet: assert property (@(posedge clk) disable iff (reset)
      !(|(status_q & mask_view)) |=> !irq)
      else $error("interrupt raised with nothing pending");

   a_ctrl_enable: assert property (@(posedge clk) disable iff (reset)
      !reset |=> ctrl_out.function_enable == $past(function_enable_q))
      else $error("function enable output does not follow register");

   a_ctrl_state: assert property (@(posedge clk) disable iff (reset)
      !reset |=> ctrl_out.address_state_enable == $past(address_state_enable_q))
      else $error("address state output does not follow register");

endmodule

// ===== usb_host_model.sv
// Host-side model: start-of-frame packets and bus event pulses
module usb_host_model (
   input wire logic clk,
   output usb_state_pkg::sof_event_type sof_out,
   output usb_state_pkg::bus_event_type ev_out
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      sof_out = '0;
      ev_out = '0;
   end

   // Identifier first, end of packet after gap cycles; frame and error only valid with eop
   task automatic sof(input logic [10:0] f, input logic e, input int gap);
      @(posedge clk);
      sof_out.sof_pid <= 1'b1;
      @(posedge clk);
      sof_out.sof_pid <= 1'b0;
      repeat (gap) @(posedge clk);
      sof_out.sof_eop <= 1'b1;
      sof_out.sof_frame <= f;
      sof_out.sof_error <= e;
      @(posedge clk);
      sof_out.sof_eop <= 1'b0;
      sof_out.sof_frame <= ~f;
      sof_out.sof_error <= ~e;
   endtask

   // One-cycle event pulse, bus reset end included
   task automatic pulse(input usb_state_pkg::bus_event_type e);
      @(posedge clk);
      ev_out <= e;
      @(posedge clk);
      ev_out <= '0;
   endtask
endmodule

// ===== tb.sv
// Self-checking bench for the device state, frame capture and mask block
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hF;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic avs_response_err;
   usb_state_pkg::sof_event_type sof_in;
   usb_state_pkg::bus_event_type events_in;
   logic [7:0] frame_high_byte;
   logic [7:0] frame_low_byte;
   usb_state_pkg::device_ctrl_type ctrl_out;
   logic irq;
   int fails = 0;
   int checks = 0;
   logic [15:0] rnd = 16'hED21;
   logic [31:0] rd;
   logic [31:0] mexp;
   logic [31:0] valid;
   logic rerr;
   logic e;

   usb_device_state_irq i_usb_device_state_irq (.clk, .reset, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response_err, .sof_in,
      .events_in, .frame_high_byte, .frame_low_byte, .ctrl_out, .irq);
   usb_host_model i_usb_host_model (.clk(clk), .sof_out(sof_in), .ev_out(events_in));

   always #12.5 clk = ~clk;

   // ****************************************************
   // Helpers
   // ****************************************************
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction

   function automatic logic [31:0] frame_exp(input logic [10:0] f, input logic err);
      return {14'h0000, ~err, err, 5'h00, f};
   endfunction

   task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= ~wr;
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      check("waitrequest", {31'h0, avs_waitrequest}, 32'h0);
      rd = avs_readdata;
      rerr = avs_response_err;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string name);
      access(1'b0, a, 32'h0);
      check(name, rd, exp);
   endtask

   task automatic irqchk(input logic exp);
      repeat (3) @(posedge clk);
      #1 check("irq", {31'h0, irq}, {31'h0, exp});
   endtask

   task automatic stop_test;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      stop_test();
   end

   // ****************************************************
   // Scenarios
   // ****************************************************
   initial begin
      valid = {18'h0, usb_state_pkg::irq_valid_bits};
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      rdchk(usb_state_pkg::irq_mask_state_off, 32'h00001200, "mask");
      rdchk(usb_state_pkg::function_address_off, 32'h0, "faddr");
      rdchk(usb_state_pkg::device_state_off, 32'h0, "state");
      access(1'b0, 8'h0C, 32'h0);
      check("unmapped", {31'h0, rerr}, 32'h1);
      // Random set and clear writes against a mask kept here
      mexp = 32'h00001200;
      for (int i = 0; i < 8; i++) begin
         rnd = lfsr(rnd);
         access(1'b1, usb_state_pkg::irq_enable_set_off, {16'h0, rnd});
         mexp = mexp | ({16'h0, rnd} & valid);
         rnd = lfsr(rnd);
         access(1'b1, usb_state_pkg::irq_enable_clear_off, {16'h0, rnd});
         mexp = mexp & ~({16'h0, rnd} & valid);
         rdchk(usb_state_pkg::irq_mask_state_off, mexp | 32'h1000, "mask");
      end
      // Address loaded before address state, configured only in address state
      rnd = lfsr(rnd);
      access(1'b1, usb_state_pkg::function_address_off, {23'h0, 1'b1, 1'b0, rnd[6:0]});
      rdchk(usb_state_pkg::function_address_off, {23'h0, 1'b1, 1'b0, rnd[6:0]}, "faddr");
      irqchk(1'b0);
      check("addr", {25'h0, ctrl_out.function_addr_value}, {25'h0, rnd[6:0]});
      check("fen", {31'h0, ctrl_out.function_enable}, 32'h1);
      access(1'b1, usb_state_pkg::device_state_off, 32'h1);
      rdchk(usb_state_pkg::device_state_off, 32'h1, "state");
      access(1'b1, usb_state_pkg::device_state_off, 32'h0);
      rdchk(usb_state_pkg::device_state_off, 32'h1, "state");
      access(1'b1, usb_state_pkg::device_state_off, 32'h3);
      rdchk(usb_state_pkg::device_state_off, 32'h3, "state");
      check("ctrl state", {30'h0, ctrl_out.configured_state, ctrl_out.address_state_enable}, 32'h3);
      access(1'b1, usb_state_pkg::device_state_off, 32'h1);
      rdchk(usb_state_pkg::device_state_off, 32'h1, "state");
      access(1'b1, usb_state_pkg::function_address_off, {25'h0, rnd[6:0]});
      irqchk(1'b0);
      check("fen", {31'h0, ctrl_out.function_enable}, 32'h0);
      // Good frame then errored frame; flags read in the gap after the identifier
      for (int i = 0; i < 2; i++) begin
         rnd = lfsr(rnd);
         e = i[0];
         fork
            i_usb_host_model.sof(rnd[10:0], e, 20);
            begin
               repeat (4) @(posedge clk);
               access(1'b0, usb_state_pkg::irq_status_off, 32'h0);
               check("sof status", rd & 32'h800, 32'h800);
               access(1'b0, usb_state_pkg::frame_info_off, 32'h0);
               check("flags", rd & 32'h30000, 32'h0);
            end
         join
         rdchk(usb_state_pkg::frame_info_off, frame_exp(rnd[10:0], e), "frame");
         check("bytes", {16'h0, frame_high_byte, frame_low_byte}, {19'h0, ~e, 1'b0, rnd[10:4], e, rnd[2:0]});
      end
      // Interrupt line against status and mask
      access(1'b1, usb_state_pkg::irq_clear_off, 32'h3B3F);
      access(1'b1, usb_state_pkg::irq_enable_clear_off, 32'h3FFF);
      irqchk(1'b0);
      i_usb_host_model.pulse(10'h040);
      irqchk(1'b0);
      access(1'b1, usb_state_pkg::irq_enable_set_off, 32'h4);
      irqchk(1'b1);
      access(1'b1, usb_state_pkg::irq_clear_off, 32'h4);
      irqchk(1'b0);
      i_usb_host_model.pulse(10'h002);
      irqchk(1'b1);
      access(1'b0, usb_state_pkg::irq_status_off, 32'h0);
      check("bus reset", rd & 32'h1000, 32'h1000);
      i_usb_host_model.pulse(10'h00D);
      access(1'b0, usb_state_pkg::irq_status_off, 32'h0);
      check("events", rd & 32'h2300, 32'h2300);
      rdchk(usb_state_pkg::irq_mask_state_off, 32'h00001200, "mask");
      stop_test();
   end
endmodule
